// ===== period_timer_consts.vh
// Purpose: Shared constants of the eight-bit period timer.
// Assumes: Included by its bare name from the design file.
// Notes:   Definitions only, no logic.
`ifndef PERIOD_TIMER_CONSTS_VH
`define PERIOD_TIMER_CONSTS_VH

// Reset values
`define TMR_COUNT_RESET   8'h00
`define TMR_PERIOD_RESET  8'hFF
`define TMR_PRE_RESET     7'h00
`define TMR_POST_RESET    4'h0
`define TMR_CTRL_RESET    8'h00
`define TMR_MODE_RESET    5'h00

// Mode field layout
`define TMR_MODE_MAJ_HI   4
`define TMR_MODE_MAJ_LO   3
`define TMR_MODE_OPT_HI   2
`define TMR_MODE_OPT_LO   0

// Major modes
`define TMR_MAJ_FREE      2'h0
`define TMR_MAJ_ONESHOT   2'h1
`define TMR_MAJ_MONO      2'h2

// Option codes of the low three mode bits
`define TMR_OPT_SOFT      3'h0
`define TMR_OPT_1         3'h1
`define TMR_OPT_2         3'h2
`define TMR_OPT_3         3'h3
`define TMR_OPT_4         3'h4
`define TMR_OPT_5         3'h5
`define TMR_OPT_6         3'h6
`define TMR_OPT_7         3'h7

// Instruction clock is the system clock divided by four
`define TMR_QTR_LAST      2'h3

`endif

// ===== period_timer.v
// Purpose: Eight-bit period timer with prescaler, postscaler and external reset/gate.
// Assumes: MCLK is the system clock; timer clock and reset sources are asynchronous pins.
// Notes:   Register bits are plain ports; writes are one-cycle strobes with data.
// What this block does
// - Count advances on each rising edge of the prescaler output.
// - Count equal to period signals postscaler and clears count next tick.
// - Prescaler divides by one up to 128, chosen by software.
// - Postscaler counts period matches, ratio one up to sixteen.
// - Device reset clears count and sets period to all ones.
// - Count write, control write, reset or external reset clear pre/postscaler.
// - Control write leaves the count untouched.
// - Free-running match returns count to zero and bumps postscaler.
// - Postscaler equal to select gives one timer-clock pulse and clears.
// - One-shot match clears on bit; restart needs on bit cycled.
// - One-shot ignores nonzero postscaler select.
// - Monostable match keeps on bit; next external event restarts.
// - Gate modes halt counting while gate inactive.
// - Reset modes clear count on level or edge as chosen.
// - Per-timer select picks external reset input controlling start/stop/reset.
// - Postscaler match sets interrupt flag; enable gates it to core.
// - Flag set syncs to instruction clock, within two; software clears.
// - Sync bit aligns prescaler output to instruction clock.
// - Clock-sync bit syncs on bit to timer clock, losing up to one edge.
// - Clock-sync clear syncs on bit to instruction clock, no edge lost.
// - Count and period are readable and writable eight-bit registers.
// - Five-bit mode: upper two pick major mode, lower three the option.
`timescale 1ns/10ps
`default_nettype none
`include "period_timer_consts.vh"

module period_timer #(
	parameter RST_SOURCES = 4,
	parameter SEL_W       = 2
) (
	input  wire                   MCLK,
	input  wire                   RSTN,
	input  wire                   TIMER_INPUT_CLOCK,
	input  wire [RST_SOURCES-1:0] EXTERNAL_RESET_SIGNAL,
	input  wire [SEL_W-1:0]       RESET_SOURCE_SELECT,
	input  wire                   CTRL_WRITE,
	input  wire                   CTRL_ON,
	input  wire [2:0]             CTRL_PRESCALE_SELECT,
	input  wire [3:0]             CTRL_POST_DIVIDE_SELECT,
	input  wire [4:0]             CTRL_MODE,
	input  wire                   CTRL_PRESCALE_OUTPUT_SYNC,
	input  wire                   CTRL_ENABLE_CLOCK_DOMAIN_SYNC,
	input  wire                   COUNT_WRITE,
	input  wire [7:0]             COUNT_WDATA,
	input  wire                   PERIOD_WRITE,
	input  wire [7:0]             PERIOD_WDATA,
	input  wire                   MATCH_IRQ_ENABLE,
	input  wire                   IRQ_FLAG_CLEAR,
	output reg  [7:0]             TIMER_COUNT_VALUE,
	output reg  [7:0]             PERIOD_VALUE,
	output reg                    ON_STATUS,
	output reg                    POSTSCALED_PULSE,
	output reg                    PERIOD_MATCH,
	output reg                    IRQ_FLAG,
	output reg                    IRQ_REQUEST
);

	// Divide ratio minus one for a prescale select of 0..7
	function [6:0] pre_limit;
		input [2:0] sel;
		begin
			pre_limit = (7'h01 << sel) - 7'h01;
		end
	endfunction

	reg  [1:0]             rst_sync_r;
	wire                   rst_n;
	reg                    tin_s1_r, tin_s2_r, tin_d_r;
	reg  [RST_SOURCES-1:0] ers_s1_r, ers_s2_r;
	reg                    ers_d_r;
	reg  [1:0]             qtr_r;
	reg  [2:0]             pre_sel_r;
	reg  [3:0]             post_sel_r;
	reg  [4:0]             mode_r;
	reg                    prescale_output_sync_r, enable_clock_domain_sync_r;
	reg                    on_eff_r, started_r, pre_pend_r, irq_pend_r;
	reg  [6:0]             pre_cnt_r;
	reg  [3:0]             post_cnt_r;

	// Release reset through two flops; assertion stays asynchronous
	always @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	// Pin synchronisers; first stage feeds only the second
	always @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tin_s1_r <= 1'b0;
			tin_s2_r <= 1'b0;
			tin_d_r  <= 1'b0;
			ers_s1_r <= {RST_SOURCES{1'b0}};
			ers_s2_r <= {RST_SOURCES{1'b0}};
			ers_d_r  <= 1'b0;
		end
		else
		begin
			tin_s1_r <= TIMER_INPUT_CLOCK;
			tin_s2_r <= tin_s1_r;
			tin_d_r  <= tin_s2_r;
			ers_s1_r <= EXTERNAL_RESET_SIGNAL;
			ers_s2_r <= ers_s1_r;
			ers_d_r  <= ers_s2_r[RESET_SOURCE_SELECT];
		end
	end

	wire       tin_edge = tin_s2_r & ~tin_d_r;
	wire       ers      = ers_s2_r[RESET_SOURCE_SELECT];
	wire       ers_rise = ers & ~ers_d_r;
	wire       ers_fall = ~ers & ers_d_r;
	wire       qtr_tick = (qtr_r == `TMR_QTR_LAST);
	wire [1:0] major    = mode_r[`TMR_MODE_MAJ_HI:`TMR_MODE_MAJ_LO];
	wire [2:0] opt      = mode_r[`TMR_MODE_OPT_HI:`TMR_MODE_OPT_LO];
	wire       is_free  = (major == `TMR_MAJ_FREE);
	wire       is_os    = (major == `TMR_MAJ_ONESHOT);
	wire       is_mono  = (major == `TMR_MAJ_MONO);

	// Gate level in free-running gate and level-reset options
	reg gate_ok;
	always @*
	begin
		gate_ok = 1'b1;
		if (is_free)
		begin
			case (opt)
				`TMR_OPT_1: gate_ok = ers;
				`TMR_OPT_2: gate_ok = ~ers;
				`TMR_OPT_6: gate_ok = ers;
				`TMR_OPT_7: gate_ok = ~ers;
				default:    gate_ok = 1'b1;
			endcase
		end
	end

	// External reset event, edge or level per option
	reg ext_rst;
	always @*
	begin
		case (opt)
			`TMR_OPT_3: ext_rst = is_free & (ers_rise | ers_fall);
			`TMR_OPT_4: ext_rst = ers_rise;
			`TMR_OPT_5: ext_rst = ers_fall;
			`TMR_OPT_6: ext_rst = ~ers;
			`TMR_OPT_7: ext_rst = ers;
			default:    ext_rst = 1'b0;
		endcase
		if (is_mono)
			ext_rst = 1'b0;
	end

	// Start edge in one-shot and monostable options
	reg start_ev;
	always @*
	begin
		case (opt)
			`TMR_OPT_1: start_ev = ers_rise;
			`TMR_OPT_4: start_ev = ers_rise;
			`TMR_OPT_6: start_ev = ers_rise;
			`TMR_OPT_2: start_ev = ers_fall;
			`TMR_OPT_5: start_ev = ers_fall;
			`TMR_OPT_7: start_ev = ers_fall;
			`TMR_OPT_3: start_ev = ers_rise | ers_fall;
			default:    start_ev = 1'b0;
		endcase
	end

	// With clock sync the on bit moves on a timer edge, which is then not counted
	wire on_change = (on_eff_r != ON_STATUS);
	wire consume   = enable_clock_domain_sync_r & tin_edge & on_change;
	wire soft_go   = (opt == `TMR_OPT_SOFT);
	wire run       = on_eff_r & gate_ok & (is_free | soft_go | started_r) & ~ext_rst;
	wire pre_out   = run & tin_edge & ~consume & (pre_cnt_r == pre_limit(pre_sel_r));
	wire tick      = prescale_output_sync_r ? (pre_pend_r & qtr_tick) : pre_out;
	wire match     = tick & (TIMER_COUNT_VALUE == PERIOD_VALUE);
	wire [3:0] post_lim = is_os ? `TMR_POST_RESET : post_sel_r;
	wire post_ev   = match & (post_cnt_r == post_lim);
	wire scal_clr  = COUNT_WRITE | CTRL_WRITE | ext_rst;

	// Instruction clock phase and control fields
	always @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			qtr_r      <= 2'h0;
			pre_sel_r  <= 3'h0;
			post_sel_r <= `TMR_POST_RESET;
			mode_r     <= `TMR_MODE_RESET;
			prescale_output_sync_r    <= 1'b0;
			enable_clock_domain_sync_r    <= 1'b0;
			ON_STATUS  <= 1'b0;
		end
		else
		begin
			qtr_r <= qtr_r + 2'h1;
			if (CTRL_WRITE)
			begin
				pre_sel_r  <= CTRL_PRESCALE_SELECT;
				post_sel_r <= CTRL_POST_DIVIDE_SELECT;
				mode_r     <= CTRL_MODE;
				prescale_output_sync_r    <= CTRL_PRESCALE_OUTPUT_SYNC;
				enable_clock_domain_sync_r    <= CTRL_ENABLE_CLOCK_DOMAIN_SYNC;
				ON_STATUS  <= CTRL_ON;
			end
			else if (match & is_os)
				ON_STATUS <= 1'b0;
		end
	end

	// Effective on bit, synchronised to timer clock or instruction clock
	always @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
			on_eff_r <= 1'b0;
		else if (enable_clock_domain_sync_r ? tin_edge : qtr_tick)
			on_eff_r <= ON_STATUS;
	end

	// Edge-start arming; monostable rearms on the next external edge
	always @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
			started_r <= 1'b0;
		else if (!on_eff_r || match)
			started_r <= 1'b0;
		else if (!is_free && start_ev)
			started_r <= 1'b1;
	end

	// Prescaler counter and optional sync hold
	always @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_cnt_r  <= `TMR_PRE_RESET;
			pre_pend_r <= 1'b0;
		end
		else
		begin
			if (scal_clr)
				pre_cnt_r <= `TMR_PRE_RESET;
			else if (pre_out)
				pre_cnt_r <= `TMR_PRE_RESET;
			else if (run & tin_edge & ~consume)
				pre_cnt_r <= pre_cnt_r + 7'h01;
			// Held tick waits for the next instruction clock phase
			if (scal_clr)
				pre_pend_r <= 1'b0;
			else if (pre_out)
				pre_pend_r <= 1'b1;
			else if (qtr_tick)
				pre_pend_r <= 1'b0;
		end
	end

	// Count and period registers
	always @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			TIMER_COUNT_VALUE <= `TMR_COUNT_RESET;
			PERIOD_VALUE      <= `TMR_PERIOD_RESET;
		end
		else
		begin
			if (COUNT_WRITE)
				TIMER_COUNT_VALUE <= COUNT_WDATA;
			else if (ext_rst)
				TIMER_COUNT_VALUE <= `TMR_COUNT_RESET;
			else if (match)
				TIMER_COUNT_VALUE <= `TMR_COUNT_RESET;
			else if (tick)
				TIMER_COUNT_VALUE <= TIMER_COUNT_VALUE + 8'h01;
			if (PERIOD_WRITE)
				PERIOD_VALUE <= PERIOD_WDATA;
		end
	end

	// Postscaler counts period matches
	always @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
			post_cnt_r <= `TMR_POST_RESET;
		else if (scal_clr || post_ev)
			post_cnt_r <= `TMR_POST_RESET;
		else if (match)
			post_cnt_r <= post_cnt_r + 4'h1;
	end

	// Output pulses last until the next timer input edge
	always @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			POSTSCALED_PULSE <= 1'b0;
			PERIOD_MATCH     <= 1'b0;
		end
		else
		begin
			if (post_ev)
				POSTSCALED_PULSE <= 1'b1;
			else if (tin_edge)
				POSTSCALED_PULSE <= 1'b0;
			if (match)
				PERIOD_MATCH <= 1'b1;
			else if (tin_edge)
				PERIOD_MATCH <= 1'b0;
		end
	end

	// Flag sets on an instruction clock phase; a set beats a clear
	always @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_pend_r  <= 1'b0;
			IRQ_FLAG    <= 1'b0;
			IRQ_REQUEST <= 1'b0;
		end
		else
		begin
			if (post_ev)
				irq_pend_r <= 1'b1;
			else if (qtr_tick)
				irq_pend_r <= 1'b0;
			if (irq_pend_r & qtr_tick)
				IRQ_FLAG <= 1'b1;
			else if (IRQ_FLAG_CLEAR)
				IRQ_FLAG <= 1'b0;
			IRQ_REQUEST <= IRQ_FLAG & MATCH_IRQ_ENABLE;
		end
	end

endmodule // period_timer
`default_nettype wire

// ===== period_timer_checker.sv
// Purpose: Port-level checks of the period timer.
// Assumes: Bound to period_timer; one clock, MCLK.
// Notes:   Pulse bound assumes a timer input period of 8 MCLK.
`timescale 1ns/10ps
`default_nettype none
module period_timer_checker (
	input wire logic       MCLK,
	input wire logic       RSTN,
	input wire logic       COUNT_WRITE,
	input wire logic [7:0] COUNT_WDATA,
	input wire logic       PERIOD_WRITE,
	input wire logic [7:0] PERIOD_WDATA,
	input wire logic       MATCH_IRQ_ENABLE,
	input wire logic       IRQ_FLAG_CLEAR,
	input wire logic [7:0] TIMER_COUNT_VALUE,
	input wire logic [7:0] PERIOD_VALUE,
	input wire logic       POSTSCALED_PULSE,
	input wire logic       PERIOD_MATCH,
	input wire logic       IRQ_FLAG,
	input wire logic       IRQ_REQUEST
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RSTN);
	a_reset_values: assert property ($rose(RSTN) |-> PERIOD_VALUE == 8'hFF && TIMER_COUNT_VALUE == 8'h00)
		else $error("reset values wrong");
	a_count_load: assert property (COUNT_WRITE |=> TIMER_COUNT_VALUE == $past(COUNT_WDATA))
		else $error("count write lost");
	a_period_load: assert property (PERIOD_WRITE |=> PERIOD_VALUE == $past(PERIOD_WDATA))
		else $error("period write lost");
	a_period_hold: assert property (!PERIOD_WRITE |=> $stable(PERIOD_VALUE))
		else $error("period changed unasked");
	a_irq_gate: assert property (IRQ_REQUEST == ($past(IRQ_FLAG) & $past(MATCH_IRQ_ENABLE)))
		else $error("request not flag and enable");
	a_flag_sticky: assert property (IRQ_FLAG && !IRQ_FLAG_CLEAR |=> IRQ_FLAG)
		else $error("flag dropped by itself");
	a_flag_clear: assert property (IRQ_FLAG_CLEAR && !POSTSCALED_PULSE |=> !IRQ_FLAG)
		else $error("flag not cleared");
	a_pulse_match: assert property ($rose(POSTSCALED_PULSE) |-> PERIOD_MATCH)
		else $error("pulse without period match");
	a_match_period: assert property ($rose(PERIOD_MATCH) |-> $past(TIMER_COUNT_VALUE) == $past(PERIOD_VALUE))
		else $error("match at wrong count");
	a_pulse_width: assert property ($rose(POSTSCALED_PULSE) |-> ##[1:12] !POSTSCALED_PULSE)
		else $error("pulse too long");
	a_flag_follows: assert property ($rose(POSTSCALED_PULSE) |-> ##[0:6] IRQ_FLAG)
		else $error("flag late");
	// Main scenarios reached
	cover property ($rose(POSTSCALED_PULSE));
	cover property (IRQ_REQUEST);
	cover property (IRQ_FLAG_CLEAR && IRQ_FLAG);
endmodule // period_timer_checker
`default_nettype wire

// ===== timer_far_end.sv
// Purpose: Model of the clock pin and external reset sources.
// Assumes: Driven from the bench on MCLK.
// Notes:   Pin runs at MCLK/8 and stands low when not running.
`timescale 1ns/10ps
`default_nettype none
module timer_far_end (
	input  wire logic       clk,
	input  wire logic       run,
	input  wire logic       level,
	input  wire logic [1:0] sel,
	output var  logic       pin_clk = 1'h0,
	output var  logic [3:0] sources
);
	logic [1:0] phase_r = 2'h0;
	logic       noise_r = 1'h0;
	// Toggle every 4 MCLK, so always slower than MCLK/4
	always @(posedge clk)
	begin
		phase_r <= run ? phase_r + 2'h1 : 2'h0;
		noise_r <= ~noise_r;
		if (!run)
			pin_clk <= 1'h0;
		else if (phase_r == 2'h3)
			pin_clk <= ~pin_clk;
	end
	// Unused sources wiggle so nothing leans on them
	always @*
	begin
		sources = {4{noise_r}};
		sources[sel] = level;
	end
endmodule // timer_far_end
`default_nettype wire

// ===== testbench.sv
// Purpose: Self-checking bench of the period timer.
// Assumes: Far end model supplies timer clock and reset sources.
// Notes:   Expected periods come from an integer model.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        clk = 1'h0, rstn = 1'h0, run = 1'h0, level = 1'h0, pin, pin_q = 1'h0;
	logic        cw = 1'h0, on = 1'h0, ps = 1'h0, cs = 1'h0, kw = 1'h0, pw = 1'h0, ie = 1'h0, clr = 1'h0;
	logic [1:0]  sel = 2'h0;
	logic [2:0]  pre = 3'h0;
	logic [3:0]  post = 4'h0, srcs;
	logic [4:0]  mode = 5'h00;
	logic [7:0]  kd = 8'h00, pd = 8'h00, count, period, c;
	logic        on_st, pulse, match, flag, req;
	integer      miscompares = 0, samples_checked = 0, seed = 88, edges = 0, cycles = 0, i, n, p, e0;
	period_timer i_dut (.MCLK(clk), .RSTN(rstn), .TIMER_INPUT_CLOCK(pin), .EXTERNAL_RESET_SIGNAL(srcs),
		.RESET_SOURCE_SELECT(sel), .CTRL_WRITE(cw), .CTRL_ON(on), .CTRL_PRESCALE_SELECT(pre),
		.CTRL_POST_DIVIDE_SELECT(post), .CTRL_MODE(mode), .CTRL_PRESCALE_OUTPUT_SYNC(ps),
		.CTRL_ENABLE_CLOCK_DOMAIN_SYNC(cs), .COUNT_WRITE(kw), .COUNT_WDATA(kd), .PERIOD_WRITE(pw),
		.PERIOD_WDATA(pd), .MATCH_IRQ_ENABLE(ie), .IRQ_FLAG_CLEAR(clr), .TIMER_COUNT_VALUE(count),
		.PERIOD_VALUE(period), .ON_STATUS(on_st), .POSTSCALED_PULSE(pulse), .PERIOD_MATCH(match),
		.IRQ_FLAG(flag), .IRQ_REQUEST(req));
	timer_far_end i_far (.clk(clk), .run(run), .level(level), .sel(sel), .pin_clk(pin), .sources(srcs));
	always #2.5 clk = ~clk;
	// Count pin edges; a hang ends the run
	always @(posedge clk)
	begin
		pin_q <= pin;
		edges <= edges + ((pin && !pin_q) ? 1 : 0);
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			miscompares = miscompares + 1;
			results;
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
	begin
		samples_checked = samples_checked + 1;
		if (seen !== exp)
		begin
			miscompares = miscompares + 1;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	end
	endtask
	task automatic wr(input logic k, input logic [7:0] d);
	begin
		@(posedge clk);
		kw <= k;
		pw <= !k;
		kd <= d;
		pd <= d;
		@(posedge clk);
		kw <= 1'h0;
		pw <= 1'h0;
	end
	endtask
	task automatic set_ctrl(input logic o, input logic [4:0] m, input logic [2:0] r, input logic [3:0] s);
	begin
		@(posedge clk);
		on <= o;
		mode <= m;
		pre <= r;
		post <= s;
		cw <= 1'h1;
		@(posedge clk);
		cw <= 1'h0;
	end
	endtask
	// Waits for the next rising edge of the postscaled pulse
	task automatic wait_pulse;
	begin
		for (n = 0; n < 3000 && pulse === 1'h1; n = n + 1)
			@(negedge clk);
		for (n = 0; n < 3000 && pulse !== 1'h1; n = n + 1)
			@(negedge clk);
	end
	endtask
	task automatic wait_cyc(input integer k);
		repeat (k) @(negedge clk);
	endtask
	task automatic results;
	begin
		$display("Checked %0d, miscompares %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		rstn <= 1'h1;
		wait_cyc(3);
		check(count, 8'h00);
		check(period, 8'hFF);
		run <= 1'h1;
		wr(1'h1, 8'h5A);
		set_ctrl(1'h0, 5'h00, 3'h2, 4'h1);
		wait_cyc(2);
		check(count, 8'h5A);
		$display("Test writes done");
		// Free running: edges between pulses is (p+1)(post+1)2^pre
		for (i = 0; i < 4; i = i + 1)
		begin
			p = 2 + ($random(seed) & 7);
			@(posedge clk);
			ps <= (i == 2);
			cs <= (i == 1);
			ie <= i[0];
			wr(1'h0, p[7:0]);
			set_ctrl(1'h1, 5'h00, i[2:0], i[3:0]);
			wait_pulse;
			e0 = edges;
			wait_pulse;
			check(edges - e0, (p + 1) * (i + 1) << i);
			wait_cyc(6);
			check(req, i[0]);
			@(posedge clk);
			clr <= 1'h1;
			@(posedge clk);
			clr <= 1'h0;
			wait_cyc(2);
			check(flag, 1'h0);
			set_ctrl(1'h0, 5'h00, 3'h0, 4'h0);
		end
		$display("Test free running done");
		// One shot ignores the postscaler and stops itself
		for (i = 0; i < 2; i = i + 1)
		begin
			wr(1'h1, 8'h00);
			set_ctrl(1'h1, 5'h08, 3'h0, 4'h3);
			n = 0;
			for (n = 0; n < (p + 1) * 8 + 40 && pulse !== 1'h1; n = n + 1)
				@(negedge clk);
			check(pulse, 1'h1);
			check(match, 1'h1);
			wait_cyc(20);
			check(on_st, 1'h0);
			c = count;
			wait_cyc(80);
			check(count, c);
			set_ctrl(1'h0, 5'h08, 3'h0, 4'h3);
		end
		$display("Test one shot done");
		// Gate follows the selected source; high level resets
		@(posedge clk);
		n = $random(seed);
		sel <= n[1:0];
		wr(1'h0, 8'hFF);
		set_ctrl(1'h1, 5'h01, 3'h0, 4'h0);
		wait_cyc(100);
		c = count;
		wait_cyc(100);
		check(count, c);
		@(posedge clk);
		level <= 1'h1;
		wait_cyc(100);
		check(count != c, 1'h1);
		set_ctrl(1'h1, 5'h07, 3'h0, 4'h0);
		wait_cyc(60);
		check(count, 8'h00);
		$display("Test external source done");
		// Monostable waits for a rising source edge, stops at match, rearms on the next edge
		wr(1'h0, 8'h03);
		set_ctrl(1'h1, 5'h11, 3'h0, 4'h0);
		@(posedge clk);
		level <= 1'h0;
		wait_cyc(60);
		check(count, 8'h00);
		for (i = 0; i < 2; i = i + 1)
		begin
			@(posedge clk);
			level <= 1'h1;
			wait_pulse;
			check(pulse, 1'h1);
			check(on_st, 1'h1);
			wait_cyc(60);
			check(count, 8'h00);
			@(posedge clk);
			level <= 1'h0;
			wait_cyc(60);
		end
		$display("Test monostable done");
		results;
	end
endmodule // testbench
bind period_timer period_timer_checker i_chk (.MCLK(MCLK), .RSTN(RSTN), .COUNT_WRITE(COUNT_WRITE),
	.COUNT_WDATA(COUNT_WDATA), .PERIOD_WRITE(PERIOD_WRITE), .PERIOD_WDATA(PERIOD_WDATA),
	.MATCH_IRQ_ENABLE(MATCH_IRQ_ENABLE), .IRQ_FLAG_CLEAR(IRQ_FLAG_CLEAR), .TIMER_COUNT_VALUE(TIMER_COUNT_VALUE),
	.PERIOD_VALUE(PERIOD_VALUE), .POSTSCALED_PULSE(POSTSCALED_PULSE), .PERIOD_MATCH(PERIOD_MATCH),
	.IRQ_FLAG(IRQ_FLAG), .IRQ_REQUEST(IRQ_REQUEST));
`default_nettype wire
